// file: core/sdf_pkg.sv
// Constants and types for the sigma-delta conversion timing block
// Behaviour
// - chop swaps polarity, averages successive conversions
// - sinc3 chop period is 3x1024xrate clocks
// - channel change resets, first result after two periods
// - mid-conversion step settles at third result
// - nonzero average select enables sinc4 postfilter averaging
// - zero average select disables fast settling
// - fast settling period (4+avg-1)x1024xrate, settle one
// - fast settling adds no channel change delay
// - fast settling async step gives one unsettled
// - chop in fast settling doubles settling only
// - 60 Hz notch at rate 96 keeps rate
// - sinc notch strobe every 1024xrate clocks
// - chop results average opposite polarity pairs
// - sinc4 chop period 4x1024xrate, settle two periods
package sdf_pkg;

  // Decimation and rate word
  localparam int unsigned SDF_RATE_W     = 10;
  localparam logic [9:0]  SDF_DECIM_LAST = 10'h3FF;
  localparam logic [9:0]  SDF_RATE_MIN   = 10'h001;
  localparam logic [9:0]  SDF_RATE_RST   = 10'h060;
  localparam logic [9:0]  SDF_NOTCH_RATE = 10'h060;

  // Sinc orders and averaging counts
  localparam logic [4:0]  SDF_ORDER_SINC3 = 5'h03;
  localparam logic [4:0]  SDF_ORDER_SINC4 = 5'h04;
  localparam logic [4:0]  SDF_AVG_OFF     = 5'h00;
  localparam logic [4:0]  SDF_AVG_2       = 5'h02;
  localparam logic [4:0]  SDF_AVG_8       = 5'h08;
  localparam logic [4:0]  SDF_AVG_16      = 5'h10;
  localparam logic [4:0]  SDF_ONE         = 5'h01;

  // Settling in output periods
  localparam logic [1:0]  SDF_SETTLE_CHOP = 2'h2;
  localparam logic [1:0]  SDF_SETTLE_FAST = 2'h1;

  // Register byte addresses
  localparam logic [7:0]  SDF_ADDR_MODE   = 8'h00;
  localparam logic [7:0]  SDF_ADDR_CTRL   = 8'h04;
  localparam logic [7:0]  SDF_ADDR_STATUS = 8'h08;
  localparam logic [7:0]  SDF_ADDR_TIMING = 8'h0C;

  // Mode register fields
  localparam int unsigned SDF_MODE_RATE_LSB = 0;
  localparam int unsigned SDF_MODE_NOTCH    = 10;
  localparam int unsigned SDF_MODE_AVG_LO   = 11;
  localparam int unsigned SDF_MODE_AVG_HI   = 12;
  localparam int unsigned SDF_MODE_CHOP     = 13;
  localparam int unsigned SDF_MODE_SINC3    = 14;

  // Control, status and timing fields
  localparam int unsigned SDF_CTRL_CHAN     = 0;
  localparam int unsigned SDF_STAT_SETTLING = 0;
  localparam int unsigned SDF_STAT_POL      = 1;
  localparam int unsigned SDF_STAT_SETTLED  = 2;
  localparam int unsigned SDF_STAT_FAST     = 3;
  localparam int unsigned SDF_STAT_NOTCH    = 4;
  localparam int unsigned SDF_STAT_COUNT    = 8;
  localparam int unsigned SDF_TIM_PHASES    = 0;
  localparam int unsigned SDF_TIM_SETTLE    = 8;

  typedef enum logic {SDF_SETTLE, SDF_RUN} sdf_state_type;

endpackage

// file: core/sdf_timing.sv
// Conversion timing and sequencing for the sigma-delta decimation filter
`timescale 1ns/1ps

module sdf_timing (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Sequencer and analog events
  input  wire logic        channel_change_i,
  input  wire logic        analog_step_i,
  // Filter control
  output logic             filter_reset_o,
  output logic             sinc_sample_o,
  output logic             postfilter_sample_o,
  output logic             chop_polarity_o,
  output logic [4:0]       avg_count_o,
  output logic             fast_settling_o,
  output logic             notch_60hz_active_o,
  // Results
  output logic             data_ready_o,
  output logic             result_settled_o,
  output logic             pair_average_o
);

  // All block state in one packed record
  typedef struct packed {
    // Sequencer state
    sdf_pkg::sdf_state_type state;

    // Copy of the mode register
    logic [9:0]  rate;
    logic        notch;
    logic        avg_hi;
    logic        avg_lo;
    logic        chop;
    logic        sinc3;

    // Decimation, phase and settling counters
    logic [9:0]  cyc;
    logic [9:0]  blk;
    logic [4:0]  phase;
    logic [1:0]  settle_cnt;
    logic        polarity;

    // Result settling tracking
    logic [1:0]  unsettled;
    logic [7:0]  results;
    logic        last_settled;

    // Step synchroniser and filtered level
    logic [2:0]  step_sync;
    logic        step_level;

    // Registered pulses and read data
    logic        filter_reset;
    logic        sinc_sample;
    logic        post_sample;
    logic        data_ready;
    logic        settled;
    logic        pair_avg;
    logic [31:0] rdata;
  } sdf_core_state_type;

  // Reset: settling state, rate 96, all else zero
  localparam sdf_core_state_type RESET_STATE = '{
    state:   sdf_pkg::SDF_SETTLE,
    rate:    sdf_pkg::SDF_RATE_RST,
    default: '0
  };

  // Current and next state
  sdf_core_state_type r;
  sdf_core_state_type next_r;

  // Decoded configuration
  logic [9:0] rate_eff;
  logic [4:0] avg_count;
  logic       fast;
  logic [4:0] phases;
  logic [1:0] settle_per;
  logic       notch_active;
  logic       notch_rate_hit;

  // Events and period boundaries
  logic       restart_pin;
  logic       restart_ctrl;
  logic       restart_mode;
  logic       chan_req;
  logic       phase_end;
  logic       last_block;
  logic       out_end;
  logic       settle_done;
  logic       emit;
  logic       step_event;
  logic       step_sync_pt;

  // Rate word, zero treated as the minimum
  always_comb begin
    if (r.rate == '0) begin
      rate_eff = sdf_pkg::SDF_RATE_MIN;
    end else begin
      rate_eff = r.rate;
    end
  end

  // Averaging select decode
  always_comb begin
    unique case ({r.avg_hi, r.avg_lo})
      2'h0: avg_count = sdf_pkg::SDF_AVG_OFF;
      2'h1: avg_count = sdf_pkg::SDF_AVG_2;
      2'h2: avg_count = sdf_pkg::SDF_AVG_8;
      2'h3: avg_count = sdf_pkg::SDF_AVG_16;
    endcase
    // Nonzero select enables fast settling
    fast = (avg_count != sdf_pkg::SDF_AVG_OFF);
  end

  // Filter order in notch periods per output
  always_comb begin
    if (fast) begin
      // Sinc4 plus postfilter: 4 + avg - 1 notch periods
      phases = sdf_pkg::SDF_ORDER_SINC4 + avg_count - sdf_pkg::SDF_ONE;
    end else if (r.sinc3) begin
      phases = sdf_pkg::SDF_ORDER_SINC3;
    end else begin
      phases = sdf_pkg::SDF_ORDER_SINC4;
    end
  end

  // Settling: one period in plain fast mode, two with chop
  always_comb begin
    if (fast && !r.chop) begin
      settle_per = sdf_pkg::SDF_SETTLE_FAST;
    end else begin
      settle_per = sdf_pkg::SDF_SETTLE_CHOP;
    end
  end

  // Rejection notch flag, chop mode at the notch rate only
  always_comb begin
    notch_rate_hit = (rate_eff == sdf_pkg::SDF_NOTCH_RATE);
    notch_active   = r.notch && r.chop && !fast && notch_rate_hit;
  end

  // Restart requests: pin, control bit or any mode write
  always_comb begin
    restart_pin  = channel_change_i;
    restart_ctrl = reg_wr_i
                   && (reg_addr_i == sdf_pkg::SDF_ADDR_CTRL)
                   && reg_wdata_i[sdf_pkg::SDF_CTRL_CHAN];
    restart_mode = reg_wr_i && (reg_addr_i == sdf_pkg::SDF_ADDR_MODE);
    chan_req     = restart_pin || restart_ctrl || restart_mode;
  end

  // Notch period and output period boundaries
  always_comb begin
    // Notch period ends on the last cycle of the last block
    last_block  = (r.blk == rate_eff - 10'h001);
    phase_end   = (r.cyc == sdf_pkg::SDF_DECIM_LAST) && last_block;
    out_end     = phase_end && (r.phase == phases - sdf_pkg::SDF_ONE);
    // Settling ends on the last settling period
    settle_done = (r.settle_cnt + 2'h1 == settle_per);
    emit        = out_end && (r.state == sdf_pkg::SDF_RUN || settle_done);
  end

  // Filtered step: second and third stages must agree
  always_comb begin
    step_event   = (r.step_sync[1] == r.step_sync[2])
                   && r.step_sync[2] && !r.step_level;
    // A step on the conversion boundary counts as synchronised
    step_sync_pt = out_end;
  end

  // Next state
  always_comb begin
    next_r = r;
    // Pulses and read data default low
    next_r.filter_reset = 1'b0;
    next_r.sinc_sample  = 1'b0;
    next_r.post_sample  = 1'b0;
    next_r.data_ready   = 1'b0;
    next_r.pair_avg     = 1'b0;
    next_r.rdata        = '0;

    // Step input synchroniser
    next_r.step_sync = {r.step_sync[1:0], analog_step_i};
    // Level follows only when stages two and three agree
    if (r.step_sync[1] == r.step_sync[2]) begin
      next_r.step_level = r.step_sync[2];
    end

    // Mode register write
    // Restart follows through chan_req
    if (restart_mode) begin
      next_r.rate   = reg_wdata_i[sdf_pkg::SDF_MODE_RATE_LSB +: sdf_pkg::SDF_RATE_W];
      next_r.notch  = reg_wdata_i[sdf_pkg::SDF_MODE_NOTCH];
      next_r.avg_lo = reg_wdata_i[sdf_pkg::SDF_MODE_AVG_LO];
      next_r.avg_hi = reg_wdata_i[sdf_pkg::SDF_MODE_AVG_HI];
      next_r.chop   = reg_wdata_i[sdf_pkg::SDF_MODE_CHOP];
      next_r.sinc3  = reg_wdata_i[sdf_pkg::SDF_MODE_SINC3];
    end

    if (chan_req) begin
      // Restart modulator and filter
      next_r.state        = sdf_pkg::SDF_SETTLE;
      // Counters and chop phase back to zero
      next_r.cyc          = '0;
      next_r.blk          = '0;
      next_r.phase        = '0;
      next_r.settle_cnt   = '0;
      next_r.polarity     = 1'b0;
      next_r.unsettled    = '0;
      // One-cycle pulse to the filter
      next_r.filter_reset = 1'b1;
    end else begin
      // Decimation counters, one block per 1024 clocks
      if (r.cyc == sdf_pkg::SDF_DECIM_LAST) begin
        next_r.cyc = '0;
        if (phase_end) begin
          next_r.blk = '0;
        end else begin
          next_r.blk = r.blk + 10'h001;
        end
      end else begin
        next_r.cyc = r.cyc + 10'h001;
      end

      // Notch period strobes
      if (phase_end) begin
        next_r.sinc_sample = 1'b1;
        next_r.post_sample = fast;
        if (out_end) begin
          next_r.phase = '0;
        end else begin
          next_r.phase = r.phase + sdf_pkg::SDF_ONE;
        end
      end

      // Output period end
      if (out_end) begin
        // Swap input polarity after every conversion
        if (r.chop) begin
          next_r.polarity = !r.polarity;
        end
        if (r.state == sdf_pkg::SDF_SETTLE) begin
          next_r.settle_cnt = r.settle_cnt + 2'h1;
        end
      end

      // Result emission
      if (emit) begin
        next_r.state        = sdf_pkg::SDF_RUN;
        next_r.data_ready   = 1'b1;
        // Settled state of this result
        next_r.settled      = (r.unsettled == '0);
        next_r.last_settled = (r.unsettled == '0);
        next_r.pair_avg     = r.chop;
        // Count results, retire one unsettled
        next_r.results      = r.results + 8'h01;
        if (r.unsettled != '0) begin
          next_r.unsettled = r.unsettled - 2'h1;
        end
      end

      // Step marks later results unsettled; set wins over decrement
      if (step_event && r.state == sdf_pkg::SDF_RUN) begin
        if (step_sync_pt) begin
          // Synchronised step: only the settling periods in flight
          next_r.unsettled = settle_per - 2'h1;
        end else begin
          // Mid-conversion step costs one more result
          next_r.unsettled = settle_per;
        end
      end
    end

    // Register reads, data in following cycle only
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        sdf_pkg::SDF_ADDR_MODE: begin
          // Rate, notch, averaging, chop and sinc select
          next_r.rdata[sdf_pkg::SDF_MODE_RATE_LSB +: sdf_pkg::SDF_RATE_W] = r.rate;
          next_r.rdata[sdf_pkg::SDF_MODE_NOTCH] = r.notch;
          next_r.rdata[sdf_pkg::SDF_MODE_AVG_LO] = r.avg_lo;
          next_r.rdata[sdf_pkg::SDF_MODE_AVG_HI] = r.avg_hi;
          next_r.rdata[sdf_pkg::SDF_MODE_CHOP] = r.chop;
          next_r.rdata[sdf_pkg::SDF_MODE_SINC3] = r.sinc3;
        end
        sdf_pkg::SDF_ADDR_STATUS: begin
          // Settling, polarity, settled, fast, notch, count
          next_r.rdata[sdf_pkg::SDF_STAT_SETTLING] = (r.state == sdf_pkg::SDF_SETTLE);
          next_r.rdata[sdf_pkg::SDF_STAT_POL] = r.polarity;
          next_r.rdata[sdf_pkg::SDF_STAT_SETTLED] = r.last_settled;
          next_r.rdata[sdf_pkg::SDF_STAT_FAST] = fast;
          next_r.rdata[sdf_pkg::SDF_STAT_NOTCH] = notch_active;
          next_r.rdata[sdf_pkg::SDF_STAT_COUNT +: 8] = r.results;
        end
        sdf_pkg::SDF_ADDR_TIMING: begin
          // Notch periods per output and settle periods
          next_r.rdata[sdf_pkg::SDF_TIM_PHASES +: 5] = phases;
          next_r.rdata[sdf_pkg::SDF_TIM_SETTLE +: 2] = settle_per;
        end
        sdf_pkg::SDF_ADDR_CTRL: begin
          // Control is write-only
          next_r.rdata = '0;
        end
        default: next_r.rdata = '0; // Unmapped reads zero
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  // Register port read data
  assign reg_rdata_o         = r.rdata;

  // Filter control and mode flags
  assign filter_reset_o      = r.filter_reset;
  assign sinc_sample_o       = r.sinc_sample;
  assign postfilter_sample_o = r.post_sample;
  assign chop_polarity_o     = r.polarity;
  assign avg_count_o         = avg_count;
  assign fast_settling_o     = fast;
  assign notch_60hz_active_o = notch_active;

  // Result strobes and flags
  assign data_ready_o        = r.data_ready;
  assign result_settled_o    = r.settled;
  assign pair_average_o      = r.pair_avg;

endmodule

// file: testbench/sdf_timing_asserts.sv
// Concurrent checks on the conversion timing block ports
`timescale 1ns/1ps

module sdf_timing_asserts (
  // Clock, reset and watched ports
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       channel_change_i,
  input wire logic       filter_reset_o,
  input wire logic       sinc_sample_o,
  input wire logic       postfilter_sample_o,
  input wire logic [4:0] avg_count_o,
  input wire logic       fast_settling_o,
  input wire logic       notch_60hz_active_o,
  input wire logic       data_ready_o,
  input wire logic       pair_average_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Restart, then reset pulse and no early result
  sequence s_restart;
    channel_change_i;
  endsequence
  sequence s_quiet;
    filter_reset_o && !data_ready_o ##1 !data_ready_o [*7];
  endsequence

  // Timing and decode checks
  a_restart_quiet: assert property (s_restart |=> s_quiet)
    else $error("restart gave no reset pulse or an early result");
  a_reset_single: assert property ($rose(filter_reset_o) |=> !filter_reset_o)
    else $error("filter reset longer than one cycle");
  a_ready_pulse: assert property (data_ready_o |=> !data_ready_o [*8])
    else $error("results too close together");
  a_sinc_gap: assert property (sinc_sample_o |=> !sinc_sample_o [*8])
    else $error("sinc samples too close together");
  a_post_gated: assert property (postfilter_sample_o |-> sinc_sample_o && fast_settling_o)
    else $error("postfilter sample outside fast settling");
  a_fast_decode: assert property (fast_settling_o == (avg_count_o != 5'h00))
    else $error("fast settling flag disagrees with average count");
  a_avg_legal: assert property (avg_count_o inside {5'h00, 5'h02, 5'h08, 5'h10})
    else $error("illegal average count");
  a_notch_fast: assert property (notch_60hz_active_o |-> !fast_settling_o)
    else $error("notch flag in fast settling");
  a_pair_ready: assert property (pair_average_o |-> data_ready_o)
    else $error("pair average without a result");
endmodule

bind sdf_timing sdf_timing_asserts u_sdf_timing_asserts (
  .clk_i, .rst_n_i, .channel_change_i, .filter_reset_o, .sinc_sample_o,
  .postfilter_sample_o, .avg_count_o, .fast_settling_o, .notch_60hz_active_o,
  .data_ready_o, .pair_average_o
);

// file: testbench/sdf_timing_test.sv
// Self-checking bench for the conversion timing block
`timescale 1ns/1ps

module sdf_timing_test;
  // Design signals and bench state
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        channel_change_i = 1'b0;
  logic        analog_step_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        filter_reset_o, sinc_sample_o, postfilter_sample_o, chop_polarity_o;
  logic [4:0]  avg_count_o;
  logic        fast_settling_o, notch_60hz_active_o;
  logic        data_ready_o, result_settled_o, pair_average_o;
  int          failures, samples_checked, cycles, sinc_cnt, post_cnt;
  int          n, a, s, t;
  logic [31:0] v;
  logic [14:0] m;
  logic        p0;
  logic [14:0] cfg [4] = '{15'h6001, 15'h2001, 15'h0801, 15'h2801};

  sdf_timing u_sdf_timing (
    .clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .channel_change_i, .analog_step_i, .filter_reset_o, .sinc_sample_o,
    .postfilter_sample_o, .chop_polarity_o, .avg_count_o, .fast_settling_o,
    .notch_60hz_active_o, .data_ready_o, .result_settled_o, .pair_average_o
  );

  // Clock
  always #4 clk_i = ~clk_i;

  // Expected averaging and output period
  function automatic int avg_of(input logic [1:0] sel);
    return sel == 2'h0 ? 0 : sel == 2'h1 ? 2 : sel == 2'h2 ? 8 : 16;
  endfunction
  function automatic int per_of(input logic [14:0] md);
    int av = avg_of(md[12:11]);
    return 1024 * md[9:0] * (av != 0 ? 3 + av : (md[14] ? 3 : 4));
  endfunction

  task automatic report_and_stop;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // Cycles until the next result, bounded
  task automatic wait_rdy(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      #1;
      cnt++;
    end while (data_ready_o !== 1'b1 && cnt < 40000);
  endtask

  // Pulse counters and run limit
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (sinc_sample_o)
      sinc_cnt <= sinc_cnt + 1;
    if (postfilter_sample_o)
      post_cnt <= post_cnt + 1;
    if (cycles == 100000) begin
      failures++;
      report_and_stop;
    end
  end

  // Main sequence
  initial begin
    void'($urandom(75));
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'h00, v);
    chk("mode_rst", v, 32'h00000060);
    chk("fast_rst", fast_settling_o, 0);
    rd(8'h10, v);
    chk("unmapped", v, 32'h0);
    for (int i = 0; i < 4; i++) begin
      m = cfg[i];
      a = avg_of(m[12:11]);
      s = (a != 0 && !m[13]) ? 1 : 2;
      t = per_of(m);
      wr(8'h00, {17'h0, m});
      if (i == 3) begin
        wr(8'h04, 32'h00000001);
      end else begin
        @(posedge clk_i);
        channel_change_i <= 1'b1;
        @(posedge clk_i);
        channel_change_i <= 1'b0;
        #1;
      end
      chk("filter_reset", filter_reset_o, 1);
      wait_rdy(n);
      chk("first_ready", n, s * t);
      chk("pair", pair_average_o, m[13]);
      p0 = chop_polarity_o;
      sinc_cnt = 0;
      post_cnt = 0;
      wait_rdy(n);
      chk("period", n, t);
      chk("polarity", chop_polarity_o ^ p0, m[13]);
      chk("sinc_cnt", sinc_cnt, t / 1024);
      chk("post_cnt", post_cnt, a != 0 ? t / 1024 : 0);
      rd(8'h08, v);
      chk("status", {v[3], v[0]}, {a != 0, 1'b0});
      rd(8'h0C, v);
      chk("timing", v, (s << 8) | (t / 1024));
      if (i % 2 == 0) begin
        repeat ($urandom_range(1500, 100)) @(posedge clk_i);
        analog_step_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        analog_step_i <= 1'b0;
        for (int k = 0; k <= s; k++) begin
          wait_rdy(n);
          chk("settled", result_settled_o, k == s);
        end
      end
      $display("config %0d done", i);
    end
    for (int i = 0; i < 8; i++) begin
      m = 15'($urandom);
      m[12:11] = i[1:0];
      wr(8'h00, {17'h0, m});
      chk("avg_dec", avg_count_o, avg_of(m[12:11]));
      chk("fast_dec", fast_settling_o, m[12:11] != 2'h0);
    end
    wr(8'h00, 32'h00002460);
    chk("notch_on", notch_60hz_active_o, 1);
    wr(8'h00, 32'h00002461);
    chk("notch_off", notch_60hz_active_o, 0);
    $display("decode and notch done");
    report_and_stop;
  end
endmodule
